// >>> cptr_regs.svh
`ifndef CPTR_REGS_SVH
`define CPTR_REGS_SVH
// register byte offsets
`define CPTR_CTRL_OFF      12'h000
`define CPTR_TIMER_OFF     12'h004
`define CPTR_STAT_OFF      12'h008
`define CPTR_MB_BASE_OFF   12'h100
// each buffer: 4 words (cs, id, data0, data1)
`define CPTR_MB_STRIDE_LOG 4
// control register fields
`define CPTR_CTRL_QUANTUM_PRESCALE_FIELD_LSB 24
`define CPTR_CTRL_PROP_LSB    0
`define CPTR_CTRL_PH1_LSB     3
`define CPTR_CTRL_PH2_LSB     6
`define CPTR_CTRL_RJW_LSB     9
`define CPTR_CTRL_SMP_BIT     11
`define CPTR_CTRL_TIMER_SYNC_ENABLE_BIT    12
`define CPTR_CTRL_CLKSEL_BIT  13
`define CPTR_CTRL_MODULE_DISABLE_BIT_BIT    14
`define CPTR_CTRL_RESET       32'h0000_0000
// buffer control word fields
`define CPTR_CS_CODE_LSB   24
`define CPTR_CS_RTR_BIT    20
`define CPTR_CS_DLC_LSB    16
// buffer state codes
`define CPTR_CODE_RX_EMPTY 4'h4
`define CPTR_CODE_RX_FULL  4'h2
`define CPTR_CODE_TX_ONCE  4'hc
`define CPTR_CODE_TX_RESP  4'ha
`define CPTR_CODE_INACTIVE 4'h8
// fixed segment lengths in quanta
`define CPTR_SYNC_TQ       5'h01
`define CPTR_SEG1_ADD      5'h02
`define CPTR_SEG2_ADD      5'h01
`define CPTR_IPT_TQ        5'h02
`endif

// >>> cptr_pkg.sv
package cptr_pkg;
    // bit-timing segment within a bit
    typedef enum logic [1:0] {
        CPTR_SEG_SYNC,
        CPTR_SEG_ONE,
        CPTR_SEG_TWO
    } cptr_seg_e;
    // protocol field reported by the bit engine
    typedef enum logic [2:0] {
        CPTR_FLD_OTHER,
        CPTR_FLD_EOF,
        CPTR_FLD_INTERM,
        CPTR_FLD_DELIM
    } cptr_fld_e;
endpackage

// >>> cptr_core.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cptr_regs.svh"
// What this block does
// - tx buffer with remote bit sends remote request, then becomes rx with same id
// - received remote request compared with every tx buffer coded 0b1010
// - responding buffer with remote bit set answers with a remote frame
// - received remote request is never stored in any receive buffer
// - remote matching ignores masks; all id bits except remote bit must match
// - matched buffer joins arbitration at once, no raised priority
// - response length comes from the buffer, not the request's length code
// - dominant in intermission bit one or two starts an overload frame
// - dominant on end-of-frame bit seven while receiving starts an overload frame
// - dominant on delimiter bit eight starts an overload frame
// - timer captured at identifier start, written to timestamp at move-in end
// - with timer sync enabled, timer resets on the specific frame reception
// - clock select picks oscillator or bus clock; change only while disabled
// - prescaler divides engine clock into one time quantum
// - each bit starts with a one-quantum sync segment
// - segment one is propagation plus phase one plus 2, range 4 to 16; not clamped, the fields allow 2 to 16
// - segment two is phase two plus 1, range 2 to 8
// - with three samples, sample point marks the third sample
// - information processing time is 2 quanta
// - holding buffer moves into matched buffer on end-of-frame bit six unless error
module cptr_core
    import cptr_pkg::*;
#(
    parameter int NUM_MB  = 16,
    parameter int IDX_W   = 4
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        osc_en_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_bit_i,
    input  wire logic        fld_valid_i,
    input  wire logic [2:0]  fld_i,
    input  wire logic [2:0]  fld_bit_i,
    input  wire logic        id_start_i,
    input  wire logic        rx_done_i,
    input  wire logic        rx_err_i,
    input  wire logic        rx_rtr_i,
    input  wire logic [28:0] rx_id_i,
    input  wire logic [3:0]  rx_dlc_i,
    input  wire logic [63:0] rx_data_i,
    input  wire logic        tx_done_i,
    input  wire logic        tx_grab_i,
    output logic             tq_tick_o,
    output logic             sample_o,
    output logic             tx_point_o,
    output logic             overload_o,
    output logic             tx_req_o,
    output logic [IDX_W-1:0] tx_mb_o,
    output logic             tx_rtr_o,
    output logic [28:0]      tx_id_o,
    output logic [3:0]       tx_dlc_o,
    output logic [63:0]      tx_data_o
);
    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [15:0] timer_r;
    logic [15:0] stamp_r;
    logic [31:0] cs_r   [NUM_MB];
    logic [28:0] id_r   [NUM_MB];
    logic [63:0] data_r [NUM_MB];

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire logic [7:0] quantum_prescale_field  = ctrl_r[`CPTR_CTRL_QUANTUM_PRESCALE_FIELD_LSB +: 8];
    wire logic [2:0] prop_f   = ctrl_r[`CPTR_CTRL_PROP_LSB +: 3];
    wire logic [2:0] ph1_f    = ctrl_r[`CPTR_CTRL_PH1_LSB +: 3];
    wire logic [2:0] ph2_f    = ctrl_r[`CPTR_CTRL_PH2_LSB +: 3];
    wire logic       smp3     = ctrl_r[`CPTR_CTRL_SMP_BIT];
    wire logic       timer_sync_enable     = ctrl_r[`CPTR_CTRL_TIMER_SYNC_ENABLE_BIT];
    wire logic       clk_sel  = ctrl_r[`CPTR_CTRL_CLKSEL_BIT];
    wire logic       module_disable_bit     = ctrl_r[`CPTR_CTRL_MODULE_DISABLE_BIT_BIT];

    // engine clock enable: oscillator rate or every bus cycle
    wire logic eng_en = clk_sel ? 1'b1 : osc_en_i;
    // segment lengths in quanta
    wire logic [4:0] seg1_len = 5'({2'b00, prop_f} + {2'b00, ph1_f}) + `CPTR_SEG1_ADD;
    wire logic [4:0] seg2_raw = {2'b00, ph2_f} + `CPTR_SEG2_ADD;
    // never below the processing time
    wire logic [4:0] seg2_len = (seg2_raw < `CPTR_IPT_TQ) ? `CPTR_IPT_TQ : seg2_raw;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic        acc      = psel & penable;
    wire logic        is_ctrl  = (paddr == `CPTR_CTRL_OFF);
    wire logic        is_timer = (paddr == `CPTR_TIMER_OFF);
    wire logic        is_stat  = (paddr == `CPTR_STAT_OFF);
    wire logic [11:0] mb_off   = paddr - `CPTR_MB_BASE_OFF;
    // buffer window above the base
    wire logic        is_mb    = (paddr >= `CPTR_MB_BASE_OFF)
                                 && (mb_off[11:`CPTR_MB_STRIDE_LOG] < 8'(NUM_MB));
    wire logic [IDX_W-1:0] mb_idx = mb_off[`CPTR_MB_STRIDE_LOG +: IDX_W];
    wire logic [1:0]  mb_word  = mb_off[3:2];
    wire logic        map_ok   = is_ctrl | is_timer | is_stat | is_mb;
    // write lands with pready high
    wire logic        wr       = acc & pwrite & map_ok & pready;
    wire logic        mb_wr    = wr & is_mb;

    // read data selection
    wire logic [31:0] mb_rd = (mb_word == 2'd0) ? cs_r[mb_idx] :
                              (mb_word == 2'd1) ? {3'b000, id_r[mb_idx]} :
                              (mb_word == 2'd2) ? data_r[mb_idx][63:32] :
                                                  data_r[mb_idx][31:0];
    wire logic [31:0] rd_val = is_ctrl  ? ctrl_r :
                               is_timer ? {16'h0000, timer_r} :
                               is_stat  ? {15'h0000, tx_req_o, stamp_r} :
                               is_mb    ? mb_rd : 32'h0000_0000;

    // one wait state: answer in the second access cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_val : 32'h0000_0000;
            pslverr <= acc & ~pready & ~map_ok;
        end
    end

    // control register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_r <= `CPTR_CTRL_RESET;
        end else if (wr & is_ctrl) begin
            ctrl_r <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // prescaler and bit timing
    // ------------------------------------------------------------
    logic [7:0]  pre_cnt_r;
    logic [4:0]  tq_cnt_r;
    cptr_seg_e   seg_r;
    logic [2:0]  smp_sh_r;

    wire logic tq_now = eng_en & ~module_disable_bit & (pre_cnt_r == quantum_prescale_field);
    // last quantum of the segment
    wire logic seg_end = (seg_r == CPTR_SEG_SYNC) ? (tq_cnt_r == `CPTR_SYNC_TQ - 5'd1) :
                         (seg_r == CPTR_SEG_ONE)  ? (tq_cnt_r == seg1_len - 5'd1) :
                                                    (tq_cnt_r == seg2_len - 5'd1);

    // divider: quantum tick each quantum_prescale_field+1 engine cycles
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || module_disable_bit) begin
            pre_cnt_r <= 8'h00;
        end else if (eng_en) begin
            pre_cnt_r <= tq_now ? 8'h00 : pre_cnt_r + 8'h01;
        end
    end

    // segment sequencer: sync, segment one, segment two
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || module_disable_bit) begin
            seg_r    <= CPTR_SEG_SYNC;
            tq_cnt_r <= 5'h00;
        end else if (tq_now) begin
            if (seg_end) begin
                tq_cnt_r <= 5'h00;
                case (seg_r)
                    CPTR_SEG_SYNC: seg_r <= CPTR_SEG_ONE;
                    CPTR_SEG_ONE:  seg_r <= CPTR_SEG_TWO;
                    default:       seg_r <= CPTR_SEG_SYNC;
                endcase
            end else begin
                tq_cnt_r <= tq_cnt_r + 5'h01;
            end
        end
    end

    // sample point, transmit point and quantum strobes
    wire logic sample_now = tq_now & seg_end & (seg_r == CPTR_SEG_ONE);
    wire logic txpt_now   = tq_now & seg_end & (seg_r == CPTR_SEG_TWO);
    // majority of three samples
    wire logic smp_vote   = (smp_sh_r[1] & smp_sh_r[0]) | (smp_sh_r[1] & rx_bit_i)
                            | (smp_sh_r[0] & rx_bit_i);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            smp_sh_r   <= 3'b111;
            tq_tick_o  <= 1'b0;
            sample_o   <= 1'b1;
            tx_point_o <= 1'b0;
        end else begin
            tq_tick_o  <= tq_now;
            tx_point_o <= txpt_now;
            if (tq_now) begin
                smp_sh_r <= {smp_sh_r[1:0], rx_bit_i};
            end
            if (sample_now) begin
                // third sample lands on the sample point itself
                sample_o <= smp3 ? smp_vote : rx_bit_i;
            end
        end
    end

    // ------------------------------------------------------------
    // overload detection, checked at each sample point
    // ------------------------------------------------------------
    // dominant is a low level
    wire logic dom = ~rx_bit_i;
    wire logic ovl_hit = fld_valid_i & dom & (
        ((fld_i == 3'(CPTR_FLD_INTERM)) && (fld_bit_i <= 3'd1)) ||
        ((fld_i == 3'(CPTR_FLD_EOF))    && (fld_bit_i == 3'd6)) ||
        ((fld_i == 3'(CPTR_FLD_DELIM))  && (fld_bit_i == 3'd7)));
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            overload_o <= 1'b0;
        end else begin
            overload_o <= sample_now & ovl_hit;
        end
    end

    // ------------------------------------------------------------
    // free-running timer and stamp capture
    // ------------------------------------------------------------
    // sync frame, decoded below
    logic match_rx_sync;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_r <= 16'h0000;
            stamp_r <= 16'h0000;
        end else begin
            // sync reset beats the count
            if (timer_sync_enable && match_rx_sync) begin
                timer_r <= 16'h0000;
            end else if (txpt_now) begin
                timer_r <= timer_r + 16'h0001;
            end
            // stamp at identifier start
            if (id_start_i) begin
                stamp_r <= timer_r;
            end
        end
    end

    // ------------------------------------------------------------
    // matching and arbitration scans
    // ------------------------------------------------------------
    // state code of a buffer
    function automatic logic [3:0] code_of(input logic [31:0] cs);
        code_of = cs[`CPTR_CS_CODE_LSB +: 4];
    endfunction

    logic             rx_hit;
    logic [IDX_W-1:0] rx_idx;
    logic             rr_hit;
    logic [IDX_W-1:0] rr_idx;
    logic             tx_hit;
    logic [IDX_W-1:0] tx_win;
    logic [NUM_MB-1:0] pend_r;

    // lowest-index match per kind, lowest id wins arbitration
    always_comb begin
        rx_hit = 1'b0;
        rx_idx = '0;
        rr_hit = 1'b0;
        rr_idx = '0;
        tx_hit = 1'b0;
        tx_win = '0;
        for (int i = NUM_MB - 1; i >= 0; i--) begin
            if ((code_of(cs_r[i]) == `CPTR_CODE_RX_EMPTY || code_of(cs_r[i]) == `CPTR_CODE_RX_FULL)
                && id_r[i] == rx_id_i) begin
                rx_hit = 1'b1;
                rx_idx = IDX_W'(i);
            end
            // exact id compare, no masks, remote bit excluded
            if (code_of(cs_r[i]) == `CPTR_CODE_TX_RESP && id_r[i] == rx_id_i) begin
                rr_hit = 1'b1;
                rr_idx = IDX_W'(i);
            end
            // plain id priority: responders get no boost
            if (pend_r[i] && (!tx_hit || id_r[i] <= id_r[tx_win])) begin
                tx_hit = 1'b1;
                tx_win = IDX_W'(i);
            end
        end
    end
    // clean data frame into buffer 0
    assign match_rx_sync = rx_done_i & ~rx_err_i & ~rx_rtr_i & rx_hit & (rx_idx == '0);

    // ------------------------------------------------------------
    // buffer update: host writes, move-in, remote handling
    // ------------------------------------------------------------
    wire logic movein  = rx_done_i & ~rx_err_i & ~rx_rtr_i & rx_hit;
    wire logic rr_trig = rx_done_i & ~rx_err_i & rx_rtr_i & rr_hit;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pend_r <= '0;
            for (int i = 0; i < NUM_MB; i++) begin
                // every buffer starts inactive
                cs_r[i]   <= {4'h0, `CPTR_CODE_INACTIVE, 24'h00_0000};
                id_r[i]   <= 29'h0000_0000;
                data_r[i] <= 64'h0;
            end
        end else begin
            if (movein) begin
                // frame stored, code full
                cs_r[rx_idx] <= {4'h0, `CPTR_CODE_RX_FULL, 3'b000, 1'b0, rx_dlc_i, stamp_r};
                data_r[rx_idx] <= rx_data_i;
            end
            if (tx_done_i) begin
                // sent: offer withdrawn
                pend_r[tx_mb_o] <= 1'b0;
                if (cs_r[tx_mb_o][`CPTR_CS_RTR_BIT] && code_of(cs_r[tx_mb_o]) == `CPTR_CODE_TX_ONCE) begin
                    // request sent: wait for the answer, same id
                    cs_r[tx_mb_o][`CPTR_CS_CODE_LSB +: 4] <= `CPTR_CODE_RX_EMPTY;
                end else if (code_of(cs_r[tx_mb_o]) == `CPTR_CODE_TX_ONCE) begin
                    cs_r[tx_mb_o][`CPTR_CS_CODE_LSB +: 4] <= `CPTR_CODE_INACTIVE;
                end
            end
            // after the clear: new request wins
            if (rr_trig) begin
                pend_r[rr_idx] <= 1'b1;
            end
            if (mb_wr) begin
                case (mb_word)
                    2'd0: begin
                        cs_r[mb_idx]   <= pwdata;
                        pend_r[mb_idx] <= (pwdata[`CPTR_CS_CODE_LSB +: 4] == `CPTR_CODE_TX_ONCE);
                    end
                    2'd1:    id_r[mb_idx] <= pwdata[28:0];
                    2'd2:    data_r[mb_idx][63:32] <= pwdata;
                    default: data_r[mb_idx][31:0] <= pwdata;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // transmit request toward the bit engine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_req_o  <= 1'b0;
            tx_mb_o   <= '0;
            tx_rtr_o  <= 1'b0;
            tx_id_o   <= 29'h0000_0000;
            tx_dlc_o  <= 4'h0;
            tx_data_o <= 64'h0;
        end else if (!tx_grab_i) begin
            // no offer while disabled
            tx_req_o  <= tx_hit & ~module_disable_bit;
            tx_mb_o   <= tx_win;
            tx_rtr_o  <= cs_r[tx_win][`CPTR_CS_RTR_BIT];
            tx_id_o   <= id_r[tx_win];
            tx_dlc_o  <= cs_r[tx_win][`CPTR_CS_DLC_LSB +: 4];
            tx_data_o <= data_r[tx_win];
        end
    end
endmodule

// >>> cptr_core_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the protocol core
// ----------------------------------------
module cptr_core_props (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_bit_i,
    input wire logic        fld_valid_i,
    input wire logic [2:0]  fld_i,
    input wire logic [2:0]  fld_bit_i,
    input wire logic        tx_grab_i,
    input wire logic        tx_point_o,
    input wire logic        overload_o,
    input wire logic        tx_rtr_o,
    input wire logic [28:0] tx_id_o,
    input wire logic [3:0]  tx_dlc_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // apb access steps
    sequence acc_wait;
        psel && penable && !pready;
    endsequence
    sequence acc_done;
        psel && penable && pready;
    endsequence
    // dominant level at one of the overload trigger bits
    wire dom_hit = fld_valid_i && !rx_bit_i && ((fld_i == 3'h2 && fld_bit_i < 3'h2) ||
                   (fld_i == 3'h1 && fld_bit_i == 3'h6) || (fld_i == 3'h3 && fld_bit_i == 3'h7));
    chk_apb_one_wait: assert property (acc_wait |=> acc_done)
        else $error("access did not end after one wait state");
    chk_apb_first_wait: assert property (psel && penable && !$past(penable) |-> !pready)
        else $error("ready in first access cycle");
    chk_ready_qual: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    chk_err_qual: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_bit_min_len: assert property (tx_point_o |=> !tx_point_o [*3])
        else $error("bit shorter than four quanta");
    chk_ovl_cause: assert property (overload_o |-> $past(dom_hit))
        else $error("overload without dominant trigger bit");
    chk_ovl_pulse: assert property (overload_o |=> !overload_o)
        else $error("overload longer than one cycle");
    chk_tx_frozen: assert property (tx_grab_i |=> $stable({tx_rtr_o, tx_id_o, tx_dlc_o}))
        else $error("offered frame changed while held");
endmodule
bind cptr_core cptr_core_props u_props (.*);

// >>> cptr_can_node.sv
`timescale 1ns/1ps
// ----------------------------------------
// other node on the bus, behind the bit engine
// ----------------------------------------
module cptr_can_node (
    input  wire logic        clk_i,
    input  wire logic        tx_point_i,
    output logic             rx_bit_o,
    output logic             fld_valid_o,
    output logic [2:0]       fld_o,
    output logic [2:0]       fld_bit_o,
    output logic             id_start_o,
    output logic             rx_done_o,
    output logic             rx_err_o,
    output logic             rx_rtr_o,
    output logic [28:0]      rx_id_o,
    output logic [3:0]       rx_dlc_o,
    output logic [63:0]      rx_data_o,
    output logic             tx_done_o,
    output logic             tx_grab_o
);
    int miss = 0;
    // idle bus is recessive
    initial begin
        {rx_bit_o, fld_valid_o, fld_o, fld_bit_o} = 8'h80;
        {id_start_o, rx_done_o, rx_err_o, rx_rtr_o, tx_done_o, tx_grab_o} = 6'h00;
        {rx_id_o, rx_dlc_o, rx_data_o} = 97'h0;
    end
    // next bit start, bounded
    task automatic bit_start();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (tx_point_i !== 1'b1 && n < 400);
        if (n >= 400) miss++;
    endtask
    // one bus level held over a whole bit, field info released after
    task automatic bit_cond(input logic [2:0] f, input logic [2:0] b, input logic lvl);
        bit_start();
        {fld_valid_o, fld_o, fld_bit_o, rx_bit_o} <= {1'b1, f, b, lvl};
        bit_start();
        {fld_valid_o, fld_o, fld_bit_o, rx_bit_o} <= {1'b0, ~f, ~b, 1'b1};
    endtask
    // received frame, stale fields inverted
    task automatic frame(input logic rtr, input logic err, input logic [28:0] id, input logic [3:0] dlc,
                         input logic [63:0] d);
        bit_start();
        id_start_o <= 1'b1;
        @(posedge clk_i);
        id_start_o <= 1'b0;
        repeat (3) bit_start();
        {rx_done_o, rx_err_o, rx_rtr_o, rx_id_o, rx_dlc_o, rx_data_o} <= {1'b1, err, rtr, id, dlc, d};
        @(posedge clk_i);
        {rx_done_o, rx_err_o, rx_rtr_o, rx_id_o, rx_dlc_o, rx_data_o} <= {1'b0, ~err, ~rtr, ~id, ~dlc, ~d};
    endtask
    // take the offered frame onto the bus, report success
    task automatic send();
        tx_grab_o <= 1'b1;
        repeat (3) bit_start();
        {tx_grab_o, tx_done_o} <= 2'b01;
        @(posedge clk_i);
        tx_done_o <= 1'b0;
    endtask
endmodule

// >>> tb_can_protocol_timing_remote.sv
`timescale 1ns/1ps
`include "cptr_regs.svh"
module tb_can_protocol_timing_remote;
    logic        sys_clk_i = 1'b0, rst_i = 1'b1, osc_en_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, ctl;
    logic        rx_bit_i, fld_valid_i, id_start_i, rx_done_i, rx_err_i, rx_rtr_i, tx_done_i, tx_grab_i;
    logic [2:0]  fld_i, fld_bit_i;
    logic [28:0] rx_id_i, tx_id_o, ida, idb;
    logic [3:0]  rx_dlc_i, tx_dlc_o, tx_mb_o, dlb;
    logic [63:0] rx_data_i, tx_data_o, dat;
    logic        tq_tick_o, sample_o, tx_point_o, overload_o, tx_req_o, tx_rtr_o;
    logic [7:0]  ovl_tab [7] = '{8'h41, 8'h45, 8'h39, 8'h7d, 8'h48, 8'h34, 8'h42};
    int          n_errors = 0, num_checks = 0, ovl_cnt = 0, len, pre, s1, s2, b0;
    cptr_core #(.NUM_MB(16), .IDX_W(4)) dut (.*);
    cptr_can_node node (.clk_i(sys_clk_i), .tx_point_i(tx_point_o), .rx_bit_o(rx_bit_i),
        .fld_valid_o(fld_valid_i), .fld_o(fld_i), .fld_bit_o(fld_bit_i), .id_start_o(id_start_i),
        .rx_done_o(rx_done_i), .rx_err_o(rx_err_i), .rx_rtr_o(rx_rtr_i), .rx_id_o(rx_id_i),
        .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i), .tx_done_o(tx_done_i), .tx_grab_o(tx_grab_i));
    // clock, oscillator enable at half bus rate, overload counter
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) osc_en_i <= ~osc_en_i;
    always @(posedge sys_clk_i) if (overload_o === 1'b1) ovl_cnt++;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic stop_test();
        n_errors += node.miss;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk_i);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            stop_test();
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_hi(ref logic s, input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (s !== 1'b1 && n < lim);
    endtask
    task automatic gap(ref logic s, output int n);
        wait_hi(s, 400, n);
        wait_hi(s, 400, n);
    endtask
    function automatic logic [11:0] mb(int n, int off);
        return 12'h100 + 12'(n * 16 + off);
    endfunction
    function automatic logic [31:0] cs(logic [3:0] code, logic rtr, logic [3:0] dlc);
        return {4'h0, code, 3'h0, rtr, dlc, 16'h0};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(64719));
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        apb(0, `CPTR_CTRL_OFF, 0);
        chk(rd, `CPTR_CTRL_RESET);
        apb(0, 12'h00c, 0);
        chk({err, rd}, 33'h100000000);
        // bit timing: corner settings first, then random, both clock sources
        for (int i = 0; i < 6; i++) begin
            pre = $urandom_range(3, 0);
            s2 = (i == 0) ? 1 : (i == 1) ? 7 : $urandom_range(7, 1);
            s1 = (i == 0) ? 3 : (i == 1) ? 14 : $urandom_range(14, (s2 == 1) ? 3 : 2);
            ctl = {8'(pre), 9'h0, 1'b1, 1'(i), 1'b0, 1'(i > 3), 2'h0, 3'(s2),
                   3'(s1 - ((s1 > 7) ? 7 : s1)), 3'((s1 > 7) ? 7 : s1)};
            apb(1, `CPTR_CTRL_OFF, ctl);
            apb(1, `CPTR_CTRL_OFF, ctl & ~32'h4000);
            gap(tq_tick_o, len);
            chk(64'(len), 64'((pre + 1) * ((i % 2) ? 1 : 2)));
            gap(tx_point_o, len);
            chk(64'(len), 64'((pre + 1) * ((i % 2) ? 1 : 2) * (4 + s1 + s2)));
        end
        // remote request from buffer 0, then it becomes a receiver
        ida = 29'($urandom);
        apb(1, mb(0, 4), {3'h0, ida});
        apb(1, mb(0, 0), cs(`CPTR_CODE_TX_ONCE, 1'b1, 4'h0));
        wait_hi(tx_req_o, 100, len);
        chk({tx_req_o, tx_rtr_o, tx_id_o, tx_mb_o}, {2'b11, ida, 4'h0});
        node.send();
        repeat (4) @(posedge sys_clk_i);
        apb(0, mb(0, 0), 0);
        chk(rd[27:24], `CPTR_CODE_RX_EMPTY);
        apb(0, mb(0, 4), 0);
        chk(rd[28:0], ida);
        // answers to remote requests: near miss, then exact match, data and remote reply
        for (int r = 0; r < 2; r++) begin
            {idb, dlb, dat} = {29'($urandom), 4'($urandom_range(8, 0)), 32'($urandom), 32'($urandom)};
            b0 = $urandom_range(28, 0);
            apb(1, mb(2, 4), {3'h0, idb});
            apb(1, mb(2, 0), cs(`CPTR_CODE_RX_EMPTY, 1'b0, 4'h0));
            apb(1, mb(1, 4), {3'h0, idb});
            apb(1, mb(1, 8), dat[63:32]);
            apb(1, mb(1, 12), dat[31:0]);
            apb(1, mb(1, 0), cs(`CPTR_CODE_TX_RESP, 1'(r), dlb));
            node.frame(1'b1, 1'b0, idb ^ (29'h1 << b0), 4'hf - dlb, 64'h0);
            wait_hi(tx_req_o, 40, len);
            chk(tx_req_o, 1'b0);
            node.frame(1'b1, 1'b0, idb, 4'hf - dlb, 64'h0);
            wait_hi(tx_req_o, 100, len);
            chk({tx_req_o, tx_mb_o, tx_rtr_o, tx_id_o}, {1'b1, 4'h1, 1'(r), idb});
            chk({tx_dlc_o, tx_data_o}, {dlb, dat});
            node.send();
            apb(0, mb(2, 0), 0);
            chk(rd[27:24], `CPTR_CODE_RX_EMPTY);
        end
        // data frame into buffer 0: dropped on error, moved in when clean
        dat = {32'($urandom), 32'($urandom)};
        for (int e = 1; e >= 0; e--) begin
            node.frame(1'b0, 1'(e), ida, 4'h5, dat);
            repeat (4) @(posedge sys_clk_i);
            apb(0, mb(0, 0), 0);
            chk(rd[27:16], e ? {`CPTR_CODE_RX_EMPTY, 8'h10} : {`CPTR_CODE_RX_FULL, 8'h05});
        end
        apb(0, mb(0, 8), 0);
        chk(rd, dat[63:32]);
        // overload triggers and near misses
        foreach (ovl_tab[k]) begin
            len = ovl_cnt;
            node.bit_cond(ovl_tab[k][7:5], ovl_tab[k][4:2], ovl_tab[k][1]);
            repeat (2) @(posedge sys_clk_i);
            chk(64'(ovl_cnt - len), 64'(ovl_tab[k][0]));
            chk(sample_o, ovl_tab[k][1]);
        end
        stop_test();
    end
    // overall run limit
    initial begin
        #2000000;
        n_errors++;
        stop_test();
    end
endmodule
